// >>> hdl/cdt_pkg.sv
// cdt_pkg: opcode patterns, field positions and minimum cycle figures
// for the instruction decode and timing block; shared by both modules.
package cdt_pkg;

  // opcode bytes and masks
  localparam logic [7:0] OP_FAR_PTR_DS = 8'hC5;
  localparam logic [7:0] OP_FAR_PTR_ES = 8'hC4;
  localparam logic [7:0] OP_FLAGS_TO_AH = 8'h9F;
  localparam logic [7:0] OP_AH_TO_FLAGS = 8'h9E;
  localparam logic [7:0] OP_EA_LOAD = 8'h8D;
  localparam logic [7:0] OP_TABLE_XLT = 8'hD7;
  localparam logic [7:0] OP_SEG_CODE = 8'h2E;
  localparam logic [7:0] OP_SEG_STACK = 8'h36;
  localparam logic [7:0] OP_SEG_DATA = 8'h3E;
  localparam logic [7:0] OP_SEG_EXTRA = 8'h26;
  localparam logic [7:0] MASK_DW = 8'hFC;
  localparam logic [7:0] MASK_W = 8'hFE;
  localparam logic [7:0] OP_ADD_RM = 8'h00;
  localparam logic [7:0] OP_ADC_RM = 8'h10;
  localparam logic [7:0] OP_SUB_RM = 8'h28;
  localparam logic [7:0] OP_SBB_RM = 8'h18;
  localparam logic [7:0] OP_ADD_ACC = 8'h04;
  localparam logic [7:0] OP_ADC_ACC = 8'h14;
  localparam logic [7:0] OP_SUB_ACC = 8'h2C;
  localparam logic [7:0] OP_IMM_GRP = 8'h80;
  // addressing byte fields
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int W_BIT = 0;
  localparam logic [1:0] MOD_REG_DIRECT = 2'h3;
  localparam logic [2:0] SUBOP_ADD = 3'h0;
  localparam logic [2:0] SUBOP_ADC = 3'h2;
  localparam logic [2:0] SUBOP_SBB = 3'h3;
  localparam logic [2:0] SUBOP_SUB = 3'h5;

  // minimum cycle figures
  localparam int CW = 6;
  localparam logic [CW-1:0] CYC_FAR_PTR_WIDE = 6'h12;   // 18
  localparam logic [CW-1:0] CYC_FAR_PTR_NARROW = 6'h1A; // 26
  localparam logic [CW-1:0] CYC_FLAGS_TO_AH = 6'h02;
  localparam logic [CW-1:0] CYC_AH_TO_FLAGS = 6'h03;
  localparam logic [CW-1:0] CYC_EA_LOAD = 6'h06;
  localparam logic [CW-1:0] CYC_XLT_WIDE = 6'h0B;       // 11
  localparam logic [CW-1:0] CYC_XLT_NARROW = 6'h0F;     // 15
  localparam logic [CW-1:0] CYC_PREFIX = 6'h02;
  localparam logic [CW-1:0] CYC_ALU_REG = 6'h03;
  localparam logic [CW-1:0] CYC_ALU_MEM = 6'h0A;        // 10
  localparam logic [CW-1:0] CYC_IMM_REG = 6'h04;
  localparam logic [CW-1:0] CYC_IMM_MEM = 6'h10;        // 16
  localparam logic [CW-1:0] CYC_ACC_BYTE = 6'h03;
  localparam logic [CW-1:0] CYC_ACC_WORD = 6'h04;
  localparam logic [CW-1:0] CYC_WORD_PENALTY = 6'h04;
  localparam logic [CW-1:0] CYC_UNKNOWN = 6'h01;

  // decoded operation classes
  typedef enum logic [3:0] {
    CDT_OP_NONE = 4'h0,
    CDT_OP_FAR_PTR_DATASEG = 4'h1,
    CDT_OP_FAR_PTR_EXTRASEG = 4'h2,
    CDT_OP_FLAGS_TO_ACC_HIGH = 4'h3,
    CDT_OP_ACC_HIGH_TO_FLAGS = 4'h4,
    CDT_OP_EA_LOAD = 4'h5,
    CDT_OP_TABLE_XLT = 4'h6,
    CDT_OP_SEG_PREFIX = 4'h7,
    CDT_OP_ADD = 4'h8,
    CDT_OP_ADC = 4'h9,
    CDT_OP_SUB = 4'hA,
    CDT_OP_SBB = 4'hB,
    CDT_OP_ILLEGAL = 4'hF
  } cdt_op_t;

  // segment selection
  typedef enum logic [2:0] {
    CDT_SEG_DEFAULT = 3'h0,
    CDT_SEG_CODE = 3'h1,
    CDT_SEG_STACK = 3'h2,
    CDT_SEG_DATA = 3'h3,
    CDT_SEG_EXTRA = 3'h4
  } cdt_seg_t;

  typedef enum logic [1:0] {
    CDT_ST_IDLE = 2'h0,
    CDT_ST_EXEC = 2'h1,
    CDT_ST_HANDSHAKE = 2'h2
  } cdt_state_t;

endpackage

// >>> hdl/cdt_classify.sv
// cdt_classify: combinational opcode and addressing-byte classifier
// assumes the addressing byte is valid whenever the opcode needs one
`timescale 1ns/1ps
`default_nettype none
module cdt_classify
  import cdt_pkg::*;
(
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] modrm_i,
  output cdt_pkg::cdt_op_t op_o,
  output cdt_pkg::cdt_seg_t seg_o,
  output logic needs_modrm_o,
  output logic mem_form_o,
  output logic word_o,
  output logic mem_word_o
);
  logic [1:0] mode;
  logic [2:0] sub;
  logic reg_direct;

  assign mode = modrm_i[MOD_HI:MOD_LO];
  assign sub = modrm_i[REG_HI:REG_LO];
  assign reg_direct = (mode == MOD_REG_DIRECT);

  // opcode classification
  always_comb begin
    op_o = CDT_OP_ILLEGAL;
    seg_o = CDT_SEG_DEFAULT;
    needs_modrm_o = 1'b0;
    mem_form_o = 1'b0;
    word_o = opcode_i[W_BIT];
    if (opcode_i == OP_FAR_PTR_DS || opcode_i == OP_FAR_PTR_ES) begin
      needs_modrm_o = 1'b1;
      word_o = 1'b1;
      mem_form_o = 1'b1;
      if (!reg_direct) begin
        op_o = (opcode_i == OP_FAR_PTR_DS) ? CDT_OP_FAR_PTR_DATASEG //RULE1
                                           : CDT_OP_FAR_PTR_EXTRASEG; //RULE2
      end
    end else if (opcode_i == OP_FLAGS_TO_AH) begin
      op_o = CDT_OP_FLAGS_TO_ACC_HIGH; //RULE3
      word_o = 1'b0;
    end else if (opcode_i == OP_AH_TO_FLAGS) begin
      op_o = CDT_OP_ACC_HIGH_TO_FLAGS; //RULE4
      word_o = 1'b0;
    end else if (opcode_i == OP_EA_LOAD) begin
      op_o = CDT_OP_EA_LOAD; //RULE5
      needs_modrm_o = 1'b1;
      word_o = 1'b1;
    end else if (opcode_i == OP_TABLE_XLT) begin
      op_o = CDT_OP_TABLE_XLT; //RULE6
      word_o = 1'b0;
      mem_form_o = 1'b1;
    end else if (opcode_i == OP_SEG_CODE || opcode_i == OP_SEG_STACK ||
                 opcode_i == OP_SEG_DATA || opcode_i == OP_SEG_EXTRA) begin
      op_o = CDT_OP_SEG_PREFIX; //RULE7
      word_o = 1'b0;
      case (opcode_i)
        OP_SEG_CODE: seg_o = CDT_SEG_CODE;
        OP_SEG_STACK: seg_o = CDT_SEG_STACK;
        OP_SEG_DATA: seg_o = CDT_SEG_DATA;
        default: seg_o = CDT_SEG_EXTRA;
      endcase
    end else if ((opcode_i & MASK_DW) == OP_ADD_RM) begin
      op_o = CDT_OP_ADD; //RULE8
      needs_modrm_o = 1'b1;
      mem_form_o = !reg_direct;
    end else if ((opcode_i & MASK_DW) == OP_ADC_RM) begin
      op_o = CDT_OP_ADC; //RULE9
      needs_modrm_o = 1'b1;
      mem_form_o = !reg_direct;
    end else if ((opcode_i & MASK_DW) == OP_SUB_RM) begin
      op_o = CDT_OP_SUB; //RULE10
      needs_modrm_o = 1'b1;
      mem_form_o = !reg_direct;
    end else if ((opcode_i & MASK_DW) == OP_SBB_RM) begin
      op_o = CDT_OP_SBB; //RULE11
      needs_modrm_o = 1'b1;
      mem_form_o = !reg_direct;
    end else if ((opcode_i & MASK_W) == OP_ADD_ACC) begin
      op_o = CDT_OP_ADD;
    end else if ((opcode_i & MASK_W) == OP_ADC_ACC) begin
      op_o = CDT_OP_ADC;
    end else if ((opcode_i & MASK_W) == OP_SUB_ACC) begin
      op_o = CDT_OP_SUB; //RULE10
    end else if ((opcode_i & MASK_DW) == OP_IMM_GRP) begin
      needs_modrm_o = 1'b1;
      mem_form_o = !reg_direct;
      case (sub)
        SUBOP_ADD: op_o = CDT_OP_ADD; //RULE8
        SUBOP_ADC: op_o = CDT_OP_ADC;
        SUBOP_SUB: op_o = CDT_OP_SUB; //RULE10
        SUBOP_SBB: op_o = CDT_OP_SBB; //RULE11
        default: op_o = CDT_OP_ILLEGAL;
      endcase
    end
  end

  assign mem_word_o = mem_form_o && word_o;
endmodule
`default_nettype wire

// >>> hdl/cdt_decode.sv
// cdt_decode: instruction decode and minimum execution timing model
// assumes opcode/addressing bytes arrive prefetched with a valid strobe
// Overview of operation
// [RULE1] 11000101 with memory addressing byte: far pointer load, data segment, 18/26
// [RULE2] 11000100 memory operand only: far pointer load, extra segment, 18/26
// [RULE3] 10011111 copies low flags into accumulator high byte, 2 cycles
// [RULE4] 10011110 writes accumulator high byte into low flags, 3 cycles
// [RULE5] 10001101 loads effective address, not memory, into register, 6 cycles
// [RULE6] 11010111 translates accumulator low byte through table, 11/15 cycles
// [RULE7] bytes 2E,36,3E,26 are code/stack/data/extra overrides, 2 cycles each
// [RULE8] add register form 3/10 cycles, immediate form 4/16
// [RULE9] 000100dw add with carry, register 3, memory 10 cycles
// [RULE10] subtract 3/10, immediate 4/16, accumulator form 0010110w 3/4
// [RULE11] 000110dw subtract with borrow; immediate sub-op 011 takes 4/16
// [RULE12] narrow bus adds 4 cycles for word memory transfers on marked entries
// [RULE13] figures are minimum times assuming prefetched, no waits, even words
// [RULE14] memory instructions may take one or two extra handshake cycles
// [RULE15] segment override covers only the next instruction, then reverts
`timescale 1ns/1ps
`default_nettype none
module cdt_decode
  import cdt_pkg::*;
#(
  parameter int MAX_HANDSHAKE = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic narrow_bus_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] modrm_i,
  input wire logic [1:0] handshake_extra_i,
  output logic instr_ready_o,
  output cdt_pkg::cdt_op_t op_o,
  output cdt_pkg::cdt_seg_t seg_o,
  output logic [cdt_pkg::CW-1:0] cycles_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o
);
  import cdt_pkg::*;

  initial begin
    if (MAX_HANDSHAKE < 0 || MAX_HANDSHAKE > 2) begin
      $error("MAX_HANDSHAKE must be 0 to 2");
    end
  end

  typedef struct packed {
    cdt_state_t st;
    cdt_op_t op;
    cdt_seg_t seg;
    cdt_seg_t pend_seg;
    logic [CW-1:0] cycles;
    logic [CW-1:0] cnt;
    logic [1:0] hs;
    logic done;
    logic illegal;
  } cdt_state_s_t;

  cdt_state_s_t s_q;
  cdt_state_s_t s_d;

  cdt_op_t cls_op;
  cdt_seg_t cls_seg;
  logic cls_mem;
  logic cls_mem_word;

  ////////////////////////////////////////////////////////////////////////
  // classifier
  cdt_classify u_cls (
    .opcode_i(opcode_i),
    .modrm_i(modrm_i),
    .op_o(cls_op),
    .seg_o(cls_seg),
    .needs_modrm_o(),
    .mem_form_o(cls_mem),
    .word_o(),
    .mem_word_o(cls_mem_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // minimum cycle table
  function automatic logic [CW-1:0] min_cycles(input cdt_op_t op, input logic [7:0] opc,
                                              input logic mem, input logic narrow,
                                              input logic mem_word);
    logic [CW-1:0] base;
    logic marked;
    logic immgrp;
    logic acc;
    base = CYC_UNKNOWN;
    marked = 1'b0;
    immgrp = ((opc & MASK_DW) == OP_IMM_GRP);
    acc = ((opc & MASK_W) == OP_ADD_ACC) || ((opc & MASK_W) == OP_ADC_ACC) ||
          ((opc & MASK_W) == OP_SUB_ACC);
    case (op)
      CDT_OP_FAR_PTR_DATASEG, CDT_OP_FAR_PTR_EXTRASEG:
        base = narrow ? CYC_FAR_PTR_NARROW : CYC_FAR_PTR_WIDE; //RULE1 RULE2
      CDT_OP_FLAGS_TO_ACC_HIGH: base = CYC_FLAGS_TO_AH; //RULE3
      CDT_OP_ACC_HIGH_TO_FLAGS: base = CYC_AH_TO_FLAGS; //RULE4
      CDT_OP_EA_LOAD: base = CYC_EA_LOAD; //RULE5
      CDT_OP_TABLE_XLT: base = narrow ? CYC_XLT_NARROW : CYC_XLT_WIDE; //RULE6
      CDT_OP_SEG_PREFIX: base = CYC_PREFIX; //RULE7
      CDT_OP_ADD, CDT_OP_ADC, CDT_OP_SUB, CDT_OP_SBB: begin
        if (acc) begin
          base = opc[W_BIT] ? CYC_ACC_WORD : CYC_ACC_BYTE; //RULE10
        end else if (immgrp) begin
          base = mem ? CYC_IMM_MEM : CYC_IMM_REG; //RULE8 RULE11
          marked = 1'b1;
        end else begin
          base = mem ? CYC_ALU_MEM : CYC_ALU_REG; //RULE8 RULE9
          marked = 1'b1;
        end
      end
      default: base = CYC_UNKNOWN;
    endcase
    if (marked && narrow && mem_word) begin
      base = base + CYC_WORD_PENALTY; //RULE12
    end
    return base;
  endfunction

  logic [CW-1:0] new_cycles;
  logic [1:0] hs_lim;
  assign new_cycles = min_cycles(cls_op, opcode_i, cls_mem, narrow_bus_i, cls_mem_word);
  // handshake extra bounded to MAX_HANDSHAKE cycles, two at most
  assign hs_lim = (handshake_extra_i > 2'(MAX_HANDSHAKE)) ? 2'(MAX_HANDSHAKE)
                                                          : handshake_extra_i;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      CDT_ST_IDLE: begin
        if (instr_valid_i) begin
          s_d.op = cls_op;
          s_d.illegal = (cls_op == CDT_OP_ILLEGAL);
          s_d.cycles = new_cycles; //RULE13
          s_d.cnt = new_cycles;
          s_d.hs = (cls_mem && cls_op != CDT_OP_ILLEGAL) ? hs_lim : 2'h0; //RULE14
          if (cls_op == CDT_OP_SEG_PREFIX) begin
            s_d.pend_seg = cls_seg; //RULE7
            s_d.seg = CDT_SEG_DEFAULT;
          end else begin
            s_d.seg = s_q.pend_seg; //RULE15
            s_d.pend_seg = CDT_SEG_DEFAULT; //RULE15
          end
          s_d.st = CDT_ST_EXEC;
        end
      end
      CDT_ST_EXEC: begin
        s_d.cnt = s_q.cnt - 6'h01;
        if (s_q.cnt == 6'h01) begin
          if (s_q.hs != 2'h0) begin
            s_d.st = CDT_ST_HANDSHAKE;
          end else begin
            s_d.st = CDT_ST_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      CDT_ST_HANDSHAKE: begin
        s_d.hs = s_q.hs - 2'h1; //RULE14
        if (s_q.hs == 2'h1) begin
          s_d.st = CDT_ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = CDT_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: CDT_ST_IDLE, op: CDT_OP_NONE, seg: CDT_SEG_DEFAULT,
               pend_seg: CDT_SEG_DEFAULT, cycles: '0, cnt: '0, hs: 2'h0,
               done: 1'b0, illegal: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign instr_ready_o = (s_q.st == CDT_ST_IDLE);
  assign op_o = s_q.op;
  assign seg_o = s_q.seg;
  assign cycles_o = s_q.cycles;
  assign busy_o = (s_q.st != CDT_ST_IDLE);
  assign done_o = s_q.done;
  assign illegal_o = s_q.illegal;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // a byte is taken when offered while idle
  logic take;
  assign take = instr_valid_i && instr_ready_o;

  far_ptr_time_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE1
    (instr_valid_i && instr_ready_o && opcode_i == OP_FAR_PTR_DS &&
     modrm_i[7:6] != 2'h3 && handshake_extra_i == 2'h0)
    |=> (op_o == CDT_OP_FAR_PTR_DATASEG && cycles_o == ($past(narrow_bus_i) ? 6'h1A : 6'h12)))
    else $error("far pointer load timing wrong");

  far_ptr_es_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE2
    (instr_valid_i && instr_ready_o && opcode_i == OP_FAR_PTR_ES && modrm_i[7:6] == 2'h3)
    |=> illegal_o)
    else $error("register form of extra pointer load accepted");

  flags_ah_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE3
    (instr_valid_i && instr_ready_o && opcode_i == OP_FLAGS_TO_AH)
    |=> busy_o ##1 busy_o ##1 done_o)
    else $error("flags to accumulator high not 2 cycles");

  ah_flags_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE4
    (instr_valid_i && instr_ready_o && opcode_i == OP_AH_TO_FLAGS)
    |=> busy_o[*3] ##1 done_o)
    else $error("accumulator high to flags not 3 cycles");

  ea_load_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE5
    (instr_valid_i && instr_ready_o && opcode_i == OP_EA_LOAD)
    |=> (cycles_o == 6'h06 && op_o == CDT_OP_EA_LOAD))
    else $error("effective address load timing wrong");

  table_translate_byte_time_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE6
    (instr_valid_i && instr_ready_o && opcode_i == OP_TABLE_XLT && handshake_extra_i == 2'h0)
    |=> ##[11:15] done_o)
    else $error("table translate did not finish in time");

  prefix_seg_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE7
    (instr_valid_i && instr_ready_o && opcode_i == OP_SEG_STACK)
    ##1 (!instr_ready_o)[*2] ##1 (instr_valid_i && instr_ready_o && cls_op != CDT_OP_SEG_PREFIX)
    |=> seg_o == CDT_SEG_STACK)
    else $error("stack override not applied");

  alu_reg_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE9
    (instr_valid_i && instr_ready_o && (opcode_i & 8'hFC) == 8'h10 && modrm_i[7:6] == 2'h3)
    |=> cycles_o == 6'h03)
    else $error("register add with carry not 3 cycles");

  word_penalty_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE12
    (instr_valid_i && instr_ready_o && (opcode_i & 8'hFC) == 8'h18 && opcode_i[0] &&
     modrm_i[7:6] != 2'h3 && narrow_bus_i)
    |=> cycles_o == 6'h0E)
    else $error("narrow word penalty missing");

  seg_revert_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE15
    (instr_valid_i && instr_ready_o && cls_op != CDT_OP_SEG_PREFIX)
    |=> (s_q.pend_seg == CDT_SEG_DEFAULT && seg_o == $past(s_q.pend_seg)))
    else $error("override outlived its instruction");

  hs_bound_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE14
    (s_q.st == CDT_ST_HANDSHAKE) |-> ##[0:2] done_o)
    else $error("handshake stretch over two cycles");

  far_ptr_es_time_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE2
    (take && opcode_i == OP_FAR_PTR_ES && modrm_i[7:6] != 2'h3)
    |=> (op_o == CDT_OP_FAR_PTR_EXTRASEG && cycles_o == ($past(narrow_bus_i) ? 6'h1A : 6'h12)))
    else $error("extra pointer load timing wrong");

  table_translate_byte_cycles_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE6
    (take && opcode_i == OP_TABLE_XLT)
    |=> cycles_o == ($past(narrow_bus_i) ? 6'h0F : 6'h0B))
    else $error("table translate figure wrong");

  prefix_time_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE7
    (take && (opcode_i == 8'h2E || opcode_i == 8'h36 || opcode_i == 8'h3E || opcode_i == 8'h26))
    |=> busy_o ##1 busy_o ##1 done_o)
    else $error("override prefix not 2 cycles");

  add_mem_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE8
    (take && (opcode_i & 8'hFC) == 8'h00 && modrm_i[7:6] != 2'h3 && !narrow_bus_i)
    |=> (op_o == CDT_OP_ADD && cycles_o == 6'h0A))
    else $error("memory add not 10 cycles");

  sub_imm_mem_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE10
    (take && (opcode_i & 8'hFC) == 8'h80 && modrm_i[5:3] == 3'h5 &&
     modrm_i[7:6] != 2'h3 && !narrow_bus_i)
    |=> (op_o == CDT_OP_SUB && cycles_o == 6'h10))
    else $error("immediate memory subtract not 16 cycles");

  sub_acc_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE10
    (take && (opcode_i & 8'hFE) == 8'h2C)
    |=> (op_o == CDT_OP_SUB && cycles_o == ($past(opcode_i[0]) ? 6'h04 : 6'h03)))
    else $error("accumulator subtract timing wrong");

  sbb_imm_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE11
    (take && (opcode_i & 8'hFC) == 8'h80 && modrm_i[5:3] == 3'h3 && modrm_i[7:6] == 2'h3)
    |=> (op_o == CDT_OP_SBB && cycles_o == 6'h04))
    else $error("immediate borrow subtract wrong");

  done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE13
    done_o |=> !done_o)
    else $error("completion pulse longer than a cycle");

  busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE13
    busy_o |=> ($stable(op_o) && $stable(cycles_o) && $stable(seg_o)))
    else $error("outputs changed while busy");

  illegal_time_a: assert property (@(posedge clk_i) disable iff (rst_i) //RULE1 RULE2
    (take && (opcode_i & 8'hFE) == 8'hC4 && modrm_i[7:6] == 2'h3)
    |=> (illegal_o && busy_o) ##1 done_o)
    else $error("register form pointer load not refused in one cycle");
endmodule
`default_nettype wire

// >>> tb/cpu_opcode_decode_timing_bench.sv
// cpu_opcode_decode_timing_bench: self-checking bench for cdt_decode
// assumes cdt_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module cpu_opcode_decode_timing_bench
  import cdt_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // signals and instance
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic narrow_bus_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] modrm_i = 8'h00;
  logic [1:0] handshake_extra_i = 2'h0;
  logic instr_ready_o;
  cdt_op_t op_o;
  cdt_seg_t seg_o;
  logic [CW-1:0] cycles_o;
  logic busy_o;
  logic done_o;
  logic illegal_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  logic hold_valid = 1'b0;
  cdt_seg_t exp_seg = CDT_SEG_DEFAULT;
  localparam int CYC_LIMIT = 6000;
  logic [7:0] pfx_tab [4] = '{OP_SEG_CODE, OP_SEG_STACK, OP_SEG_DATA, OP_SEG_EXTRA};
  cdt_seg_t seg_tab [4] = '{CDT_SEG_CODE, CDT_SEG_STACK, CDT_SEG_DATA, CDT_SEG_EXTRA};

  cdt_decode #(.MAX_HANDSHAKE(2)) u_cdt_decode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .narrow_bus_i(narrow_bus_i),
    .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i),
    .modrm_i(modrm_i),
    .handshake_extra_i(handshake_extra_i),
    .instr_ready_o(instr_ready_o),
    .op_o(op_o),
    .seg_o(seg_o),
    .cycles_o(cycles_o),
    .busy_o(busy_o),
    .done_o(done_o),
    .illegal_o(illegal_o)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // outputs expected while idle after reset
  task automatic check_idle();
    check(instr_ready_o, 1'b1, "ready after reset");
    check(busy_o, 1'b0, "busy after reset");
    check(done_o, 1'b0, "done after reset");
    check(op_o, CDT_OP_NONE, "op after reset");
    check(seg_o, CDT_SEG_DEFAULT, "seg after reset");
    check(cycles_o, 6'h00, "cycles after reset");
    check(illegal_o, 1'b0, "illegal after reset");
  endtask

  // issue one instruction, count busy cycles, judge the answer
  task automatic run(input logic [7:0] op, input logic [7:0] m, input logic nb,
                     input logic [1:0] h, input cdt_op_t e_op, input logic [5:0] e_cyc,
                     input int e_busy);
    int n;
    n = 0;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    opcode_i <= op;
    modrm_i <= m;
    narrow_bus_i <= nb;
    handshake_extra_i <= h;
    @(posedge clk_i);
    if (hold_valid) begin
      opcode_i <= OP_FLAGS_TO_AH;
    end else begin
      instr_valid_i <= 1'b0;
    end
    #1;
    while (done_o !== 1'b1 && n < 200) begin
      if (busy_o === 1'b1) begin
        n++;
      end
      @(posedge clk_i);
      if (n >= 3) begin
        instr_valid_i <= 1'b0;
      end
      #1;
    end
    check(op_o, e_op, "decoded class");
    check(seg_o, exp_seg, "segment");
    check(cycles_o, e_cyc, "cycle figure");
    check(illegal_o, e_op == CDT_OP_ILLEGAL, "illegal flag");
    check(n[15:0], e_busy[15:0], "busy length");
    check(instr_ready_o, 1'b1, "ready with done");
    @(posedge clk_i);
    #1;
    check(done_o, 1'b0, "done one cycle");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_transfer();
    run(OP_FAR_PTR_DS, 8'h06, 1'b0, 2'h0, CDT_OP_FAR_PTR_DATASEG, 6'h12, 18);
    run(OP_FAR_PTR_DS, 8'h46, 1'b1, 2'h1, CDT_OP_FAR_PTR_DATASEG, 6'h1A, 27);
    run(OP_FAR_PTR_DS, 8'hC0, 1'b0, 2'h0, CDT_OP_ILLEGAL, 6'h01, 1);
    run(OP_FAR_PTR_ES, 8'h86, 1'b1, 2'h2, CDT_OP_FAR_PTR_EXTRASEG, 6'h1A, 28);
    run(OP_FAR_PTR_ES, 8'h06, 1'b0, 2'h3, CDT_OP_FAR_PTR_EXTRASEG, 6'h12, 20);
    run(OP_FAR_PTR_ES, 8'hDB, 1'b1, 2'h2, CDT_OP_ILLEGAL, 6'h01, 1);
    run(OP_FLAGS_TO_AH, 8'h00, 1'b1, 2'h2, CDT_OP_FLAGS_TO_ACC_HIGH, 6'h02, 2);
    run(OP_AH_TO_FLAGS, 8'h00, 1'b1, 2'h0, CDT_OP_ACC_HIGH_TO_FLAGS, 6'h03, 3);
    run(OP_EA_LOAD, 8'h06, 1'b1, 2'h2, CDT_OP_EA_LOAD, 6'h06, 6);
    run(OP_TABLE_XLT, 8'h00, 1'b0, 2'h0, CDT_OP_TABLE_XLT, 6'h0B, 11);
    run(OP_TABLE_XLT, 8'h00, 1'b1, 2'h1, CDT_OP_TABLE_XLT, 6'h0F, 16);
    $display("test transfer group done");
  endtask

  // inputs offered while busy must be ignored
  task automatic t_refuse();
    hold_valid = 1'b1;
    run(OP_FAR_PTR_DS, 8'h06, 1'b0, 2'h0, CDT_OP_FAR_PTR_DATASEG, 6'h12, 18);
    hold_valid = 1'b0;
    $display("test refuse while busy done");
  endtask

  task automatic t_prefix();
    for (int i = 0; i < 4; i++) begin
      run(pfx_tab[i], 8'h00, 1'b0, 2'h0, CDT_OP_SEG_PREFIX, 6'h02, 2);
      exp_seg = seg_tab[i];
      run(OP_FAR_PTR_DS, 8'h06, 1'b1, 2'h0, CDT_OP_FAR_PTR_DATASEG, 6'h1A, 26);
      exp_seg = CDT_SEG_DEFAULT;
      run(OP_TABLE_XLT, 8'h00, 1'b0, 2'h0, CDT_OP_TABLE_XLT, 6'h0B, 11);
    end
    run(OP_SEG_CODE, 8'h00, 1'b0, 2'h0, CDT_OP_SEG_PREFIX, 6'h02, 2);
    run(OP_SEG_EXTRA, 8'h00, 1'b0, 2'h0, CDT_OP_SEG_PREFIX, 6'h02, 2);
    exp_seg = CDT_SEG_EXTRA;
    run(OP_FAR_PTR_ES, 8'h06, 1'b0, 2'h0, CDT_OP_FAR_PTR_EXTRASEG, 6'h12, 18);
    exp_seg = CDT_SEG_DEFAULT;
    $display("test segment overrides done");
  endtask

  // prefix followed by an instruction offered while busy, taken as ready returns
  task automatic t_back_to_back();
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    opcode_i <= OP_SEG_STACK;
    narrow_bus_i <= 1'b0;
    handshake_extra_i <= 2'h0;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    opcode_i <= OP_TABLE_XLT;
    repeat (2) @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    check(op_o, CDT_OP_TABLE_XLT, "taken after prefix");
    check(seg_o, CDT_SEG_STACK, "override on next");
    check(cycles_o, 6'h0B, "translate figure");
    repeat (11) @(posedge clk_i);
    #1;
    check(done_o, 1'b1, "translate done");
    $display("test back to back done");
  endtask

  task automatic t_arith();
    run(8'h00, 8'hC0, 1'b1, 2'h2, CDT_OP_ADD, 6'h03, 3);
    run(8'h01, 8'h06, 1'b1, 2'h0, CDT_OP_ADD, 6'h0E, 14);
    run(8'h02, 8'h06, 1'b0, 2'h1, CDT_OP_ADD, 6'h0A, 11);
    run(8'h03, 8'h06, 1'b0, 2'h0, CDT_OP_ADD, 6'h0A, 10);
    run(8'h80, 8'hC0, 1'b0, 2'h0, CDT_OP_ADD, 6'h04, 4);
    run(8'h81, 8'h06, 1'b1, 2'h2, CDT_OP_ADD, 6'h14, 22);
    run(8'h04, 8'h00, 1'b0, 2'h0, CDT_OP_ADD, 6'h03, 3);
    run(8'h05, 8'h00, 1'b1, 2'h0, CDT_OP_ADD, 6'h04, 4);
    run(8'h10, 8'hC0, 1'b0, 2'h0, CDT_OP_ADC, 6'h03, 3);
    run(8'h11, 8'h46, 1'b1, 2'h0, CDT_OP_ADC, 6'h0E, 14);
    run(8'h12, 8'h06, 1'b0, 2'h0, CDT_OP_ADC, 6'h0A, 10);
    run(8'h80, 8'hD0, 1'b0, 2'h0, CDT_OP_ADC, 6'h04, 4);
    run(8'h80, 8'h16, 1'b1, 2'h0, CDT_OP_ADC, 6'h10, 16);
    run(8'h14, 8'h00, 1'b0, 2'h0, CDT_OP_ADC, 6'h03, 3);
    run(8'h2A, 8'hC0, 1'b0, 2'h0, CDT_OP_SUB, 6'h03, 3);
    run(8'h29, 8'h06, 1'b0, 2'h0, CDT_OP_SUB, 6'h0A, 10);
    run(8'h80, 8'hE8, 1'b0, 2'h0, CDT_OP_SUB, 6'h04, 4);
    run(8'h80, 8'h2E, 1'b0, 2'h2, CDT_OP_SUB, 6'h10, 18);
    run(8'h2C, 8'h00, 1'b0, 2'h0, CDT_OP_SUB, 6'h03, 3);
    run(8'h2D, 8'h00, 1'b1, 2'h0, CDT_OP_SUB, 6'h04, 4);
    run(8'h18, 8'hC0, 1'b0, 2'h0, CDT_OP_SBB, 6'h03, 3);
    run(8'h1B, 8'h86, 1'b1, 2'h0, CDT_OP_SBB, 6'h0E, 14);
    run(8'h80, 8'hD8, 1'b0, 2'h0, CDT_OP_SBB, 6'h04, 4);
    run(8'h81, 8'h1E, 1'b1, 2'h1, CDT_OP_SBB, 6'h14, 21);
    run(8'h80, 8'hC8, 1'b0, 2'h0, CDT_OP_ILLEGAL, 6'h01, 1);
    $display("test arithmetic group done");
  endtask

  // reset in mid-instruction clears a pending override as well
  task automatic t_mid_reset();
    run(OP_SEG_DATA, 8'h00, 1'b0, 2'h0, CDT_OP_SEG_PREFIX, 6'h02, 2);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    opcode_i <= OP_SEG_STACK;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    check(busy_o, 1'b1, "busy before reset");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check_idle();
    @(posedge clk_i);
    rst_i <= 1'b0;
    run(OP_FAR_PTR_DS, 8'h06, 1'b0, 2'h0, CDT_OP_FAR_PTR_DATASEG, 6'h12, 18);
    $display("test reset mid instruction done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // timeout and main sequence
  always @(posedge clk_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == CYC_LIMIT) begin
      fail_count++;
      $display("ERROR %0t run did not finish in time", $time);
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check_idle();
    $display("test reset values done");
    t_transfer();
    t_refuse();
    t_prefix();
    t_back_to_back();
    t_arith();
    t_mid_reset();
    final_report();
  end
endmodule
`default_nettype wire
